// File: pkg/lic_pkg.sv
// Shared constants and types for the lane control and configuration block.
package lic_pkg;

  // ************************************************************
  // Sizes and byte offsets
  // ************************************************************
  localparam int         NUM_CH        = 8;
  localparam int         NUM_LANES     = 4;
  localparam int         NUM_BYTES     = 12;
  localparam logic [3:0] OFS_LEVEL     = 4'h0;
  localparam logic [3:0] OFS_LOAD      = 4'h1;
  localparam logic [3:0] OFS_LOOP      = 4'h2;
  localparam logic [3:0] OFS_IN_OFF    = 4'h3;
  localparam logic [3:0] OFS_OUT_OFF   = 4'h4;
  localparam logic [3:0] OFS_RESTART   = 4'h5;
  localparam logic [3:0] OFS_PWR       = 4'h6;
  localparam logic [3:0] OFS_SENSE     = 4'h7;
  localparam logic [3:0] OFS_EQ_A      = 4'h8;
  localparam logic [3:0] OFS_EQ_B      = 4'h9;
  localparam logic [3:0] OFS_RSVD      = 4'ha;
  localparam logic [3:0] OFS_THRESH    = 4'hb;
  localparam logic [3:0] PTR_MAX       = 4'hf;

  // ************************************************************
  // Slave address and bit counting
  // ************************************************************
  localparam logic [1:0] ADDR_TOP_FIXED = 2'h3;
  localparam logic [1:0] ADDR_MID_FIXED = 2'h0;
  localparam logic [2:0] LAST_BIT       = 3'h7;

  // ************************************************************
  // Termination encodings
  // ************************************************************
  localparam logic [1:0] TERM_HIZ       = 2'h0;
  localparam logic [1:0] IN_PULL_DOWN   = 2'h1;
  localparam logic [1:0] OUT_WEAK_UP    = 2'h1;
  localparam logic [1:0] OUT_DRIVE      = 2'h2;

  // ************************************************************
  // Values after reset
  // ************************************************************
  localparam logic [7:0] RST_LOOP_EMPH  = 8'hfc;
  localparam logic [1:0] RST_EMPH       = 2'h3;
  localparam logic [7:0] RST_OFF        = 8'h00;
  localparam logic [7:0] RST_PWR        = 8'hff;
  localparam logic [7:0] RST_EQ         = 8'h00;
  localparam logic [7:0] RST_THRESH     = 8'h00;
  localparam logic [1:0] STRAP_WAIT     = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
  } lic_i2c_state_e;

endpackage

// File: hw/lic_sync.sv
// Two-flop level synchroniser for a bundle of slow or static signals.
`timescale 1ns/1ps
`default_nettype none

module lic_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      meta_r   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // lic_sync

`default_nettype wire

// File: hw/lic_top.sv
// Channel termination, lane routing and I2C configuration map.
// Summary of operation
// - Power-down input low puts every termination in high impedance.
// - Restart bit low: channel off, weak output pull-up, detector held.
// - Detection off: input pulled down, output drives only with valid level.
// - Detection on but no load: channel stays off on weak pull-up.
// - Load found without level: input pulled down, output weak.
// - Load found with level: channel active, output driving.
// - Lane loop bit high: each receiver feeds its own transmitter.
// - Lane loop bit low: A receiver feeds B and A transmitters.
// - Input and output disable bits switch buffers off independently.
// - Loop strap sets all lane loop bits at startup.
// - Configuration port is a standard-rate seven-bit I2C slave.
// - Bytes are accessed upward from the lowest; stop after any byte.
// - Three address bits come from select pins.
// - Write data fills consecutive bytes until stop.
// - Bytes are eight bits, MSB first, each acknowledged.
// - The slave never holds the clock line low.
// - Transfers always begin at byte zero; offsets are ignored.
// - Byte six powers channels down one by one.
// - Byte seven enables load sensing per channel.
// - Byte eleven holds the idle-detect threshold.
// - Configuration-source high blocks register writes.
// - Restart bit rising starts a new detect cycle.
// - First write byte after the address is thrown away.
// - Address is fixed bits plus select pins, LSB is direction.
`timescale 1ns/1ps
`default_nettype none

module lic_top (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  input  wire logic        addr_select_high_in,
  input  wire logic        addr_select_mid_in,
  input  wire logic        addr_select_low_in,
  input  wire logic        config_source_in,
  input  wire logic        power_down_n_in,
  input  wire logic        loop_strap_n_in,
  input  wire logic        detect_restart_n_in,
  input  wire logic        load_sense_a_in,
  input  wire logic        load_sense_b_in,
  input  wire logic [7:0]  level_valid_in,
  input  wire logic [7:0]  load_found_in,
  output logic      [15:0] in_term_out,
  output logic      [15:0] out_term_out,
  output logic      [7:0]  rx_enable_out,
  output logic      [7:0]  tx_enable_out,
  output logic      [7:0]  tx_from_partner_out,
  output logic      [7:0]  detect_reset_out,
  output logic      [7:0]  detect_start_out,
  output logic      [3:0]  lane_loop_n_out,
  output logic      [1:0]  emphasis_out,
  output logic      [7:0]  group_a_eq_out,
  output logic      [7:0]  group_b_eq_out,
  output logic      [7:0]  idle_threshold_out
);

  // ************************************************************
  // Start and stop detection on data edges
  // ************************************************************
  logic start_tgl_r;
  logic stop_tgl_r;

  always_ff @(negedge sda_in or negedge rstn_in)
  begin
    if (!rstn_in)
      start_tgl_r <= 1'b0;
    else if (scl_in)
      start_tgl_r <= ~start_tgl_r;
  end

  always_ff @(posedge sda_in or negedge rstn_in)
  begin
    if (!rstn_in)
      stop_tgl_r <= 1'b0;
    else if (scl_in)
      stop_tgl_r <= ~stop_tgl_r;
  end

  // ************************************************************
  // Link side, clocked by SCL
  // ************************************************************
  lic_pkg::lic_i2c_state_e st_r;
  logic [2:0]  bitcnt_r;
  logic [6:0]  shift_r;
  logic [3:0]  ptr_r;
  logic        first_r;
  logic        rw_r;
  logic        start_seen_r;
  logic [3:0]  wr_idx_r;
  logic [7:0]  wr_data_r;
  logic        wr_tgl_r;
  logic [2:0]  sel_s;
  logic [7:0]  snap_r [lic_pkg::NUM_BYTES];
  logic [7:0]  rd_byte;
  logic        new_start;
  logic        last_bit;
  logic [6:0]  my_addr;

  lic_sync #(.WIDTH(3)) u_sync_sel (
    .clk_in   (scl_in),
    .rstn_in  (rstn_in),
    .async_in ({addr_select_high_in, addr_select_mid_in, addr_select_low_in}),
    .sync_out (sel_s)
  );

  assign new_start = start_tgl_r ^ start_seen_r;
  assign last_bit  = (bitcnt_r == lic_pkg::LAST_BIT);
  assign my_addr   = {lic_pkg::ADDR_TOP_FIXED, sel_s[2],
                      lic_pkg::ADDR_MID_FIXED, sel_s[1], sel_s[0]};
  assign rd_byte   = (ptr_r <= lic_pkg::OFS_THRESH) ? snap_r[ptr_r] : 8'h00;

  always_ff @(posedge scl_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      st_r         <= lic_pkg::ST_IDLE;
      bitcnt_r     <= 3'h0;
      shift_r      <= 7'h00;
      ptr_r        <= 4'h0;
      first_r      <= 1'b1;
      rw_r         <= 1'b0;
      start_seen_r <= 1'b0;
    end
    else if (new_start)
    begin
      start_seen_r <= start_tgl_r;
      st_r         <= lic_pkg::ST_ADDR;
      bitcnt_r     <= 3'h1;
      shift_r      <= {6'h00, sda_in};
      ptr_r        <= 4'h0;
      first_r      <= 1'b1;
    end
    else
    begin
      unique case (st_r)
        lic_pkg::ST_ADDR:
        begin
          bitcnt_r <= bitcnt_r + 3'h1;
          shift_r  <= {shift_r[5:0], sda_in};
          if (last_bit)
          begin
            rw_r <= sda_in;
            st_r <= (shift_r == my_addr) ? lic_pkg::ST_ADDR_ACK
                                         : lic_pkg::ST_IDLE;
          end
        end
        lic_pkg::ST_ADDR_ACK:
          st_r <= rw_r ? lic_pkg::ST_RDATA : lic_pkg::ST_WDATA;
        lic_pkg::ST_WDATA:
        begin
          bitcnt_r <= bitcnt_r + 3'h1;
          shift_r  <= {shift_r[5:0], sda_in};
          if (last_bit)
          begin
            st_r    <= lic_pkg::ST_WACK;
            first_r <= 1'b0;
            if (!first_r && ptr_r != lic_pkg::PTR_MAX)
              ptr_r <= ptr_r + 4'h1;
          end
        end
        lic_pkg::ST_WACK:
          st_r <= lic_pkg::ST_WDATA;
        lic_pkg::ST_RDATA:
        begin
          bitcnt_r <= bitcnt_r + 3'h1;
          if (last_bit)
            st_r <= lic_pkg::ST_RACK;
        end
        lic_pkg::ST_RACK:
        begin
          st_r <= sda_in ? lic_pkg::ST_IDLE : lic_pkg::ST_RDATA;
          if (ptr_r != lic_pkg::PTR_MAX)
            ptr_r <= ptr_r + 4'h1;
        end
        default:
          st_r <= lic_pkg::ST_IDLE;
      endcase
    end
  end

  // The byte and its index stay still until the next byte, many SCL
  // periods later, so the system side may sample them after the toggle.
  always_ff @(posedge scl_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wr_data_r <= 8'h00;
      wr_idx_r  <= 4'h0;
      wr_tgl_r  <= 1'b0;
    end
    else if (!new_start && st_r == lic_pkg::ST_WDATA && last_bit
             && !first_r)
    begin
      wr_data_r <= {shift_r, sda_in};
      wr_idx_r  <= ptr_r;
      wr_tgl_r  <= ~wr_tgl_r;
    end
  end

  // Data changes on the falling edge; SDA is only ever driven here.
  always_ff @(negedge scl_in or negedge rstn_in)
  begin
    if (!rstn_in)
      sda_oe_out <= 1'b0;
    else
    begin
      unique case (st_r)
        lic_pkg::ST_ADDR_ACK, lic_pkg::ST_WACK:
          sda_oe_out <= 1'b1;
        lic_pkg::ST_RDATA:
          sda_oe_out <= ~rd_byte[lic_pkg::LAST_BIT - bitcnt_r];
        default:
          sda_oe_out <= 1'b0;
      endcase
    end
  end

  assign sda_out = 1'b0;

  // ************************************************************
  // System side crossing and startup straps
  // ************************************************************
  logic [24:0] sync_s;
  logic        wr_seen_r;
  logic        start_q_r;
  logic        stop_q_r;
  logic        busy_r;
  logic [1:0]  init_cnt_r;
  logic        init_done_r;
  logic        strap_ld;
  logic        wr_ok;
  logic        cfg_src_s;
  logic        pd_n_s;
  logic [7:0]  level_s;
  logic [7:0]  load_s;

  lic_sync #(.WIDTH(25)) u_sync_sys (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .async_in ({wr_tgl_r, start_tgl_r, stop_tgl_r, config_source_in,
                power_down_n_in, loop_strap_n_in, detect_restart_n_in,
                load_sense_a_in, load_sense_b_in, level_valid_in,
                load_found_in}),
    .sync_out (sync_s)
  );

  assign cfg_src_s = sync_s[21];
  assign pd_n_s    = sync_s[20];
  assign level_s   = sync_s[15:8];
  assign load_s    = sync_s[7:0];
  assign strap_ld  = (init_cnt_r == lic_pkg::STRAP_WAIT) && !init_done_r;
  assign wr_ok     = (sync_s[24] ^ wr_seen_r) && !cfg_src_s
                     && init_done_r;

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wr_seen_r <= 1'b0;
      start_q_r <= 1'b0;
      stop_q_r  <= 1'b0;
      busy_r    <= 1'b0;
    end
    else
    begin
      wr_seen_r <= sync_s[24];
      start_q_r <= sync_s[23];
      stop_q_r  <= sync_s[22];
      if (sync_s[23] ^ start_q_r)
        busy_r <= 1'b1;
      else if (sync_s[22] ^ stop_q_r)
        busy_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      init_cnt_r  <= 2'h0;
      init_done_r <= 1'b0;
    end
    else
    begin
      if (init_cnt_r != lic_pkg::STRAP_WAIT)
        init_cnt_r <= init_cnt_r + 2'h1;
      if (strap_ld)
        init_done_r <= 1'b1;
    end
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************
  logic [7:0] loop_emph_r;
  logic [7:0] in_off_r;
  logic [7:0] out_off_r;
  logic [7:0] restart_r;
  logic [7:0] restart_q_r;
  logic [7:0] pwr_r;
  logic [7:0] sense_r;

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      loop_emph_r        <= lic_pkg::RST_LOOP_EMPH;
      in_off_r           <= lic_pkg::RST_OFF;
      out_off_r          <= lic_pkg::RST_OFF;
      restart_r          <= lic_pkg::RST_OFF;
      pwr_r              <= lic_pkg::RST_PWR;
      sense_r            <= lic_pkg::RST_OFF;
      group_a_eq_out     <= lic_pkg::RST_EQ;
      group_b_eq_out     <= lic_pkg::RST_EQ;
      idle_threshold_out <= lic_pkg::RST_THRESH;
    end
    else if (strap_ld)
    begin
      loop_emph_r <= {{4{sync_s[19]}}, lic_pkg::RST_EMPH, 2'h0};
      restart_r   <= {8{sync_s[18]}};
      sense_r     <= {4{sync_s[17], sync_s[16]}};
    end
    else if (wr_ok)
    begin
      case (wr_idx_r)
        lic_pkg::OFS_LOOP:    loop_emph_r <= {wr_data_r[7:2], 2'h0};
        lic_pkg::OFS_IN_OFF:  in_off_r <= wr_data_r;
        lic_pkg::OFS_OUT_OFF: out_off_r <= wr_data_r;
        lic_pkg::OFS_RESTART: restart_r <= wr_data_r;
        lic_pkg::OFS_PWR:     pwr_r <= wr_data_r;
        lic_pkg::OFS_SENSE:   sense_r <= wr_data_r;
        lic_pkg::OFS_EQ_A:    group_a_eq_out <= wr_data_r;
        lic_pkg::OFS_EQ_B:    group_b_eq_out <= wr_data_r;
        lic_pkg::OFS_THRESH:  idle_threshold_out <= wr_data_r;
        default:              ;
      endcase
    end
  end

  // A read must not see a byte tear, so the copy freezes for the frame.
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      for (int i = 0; i < lic_pkg::NUM_BYTES; i++)
        snap_r[i] <= 8'h00;
    end
    else if (!busy_r)
    begin
      snap_r[lic_pkg::OFS_LEVEL]   <= level_s;
      snap_r[lic_pkg::OFS_LOAD]    <= load_s;
      snap_r[lic_pkg::OFS_LOOP]    <= loop_emph_r;
      snap_r[lic_pkg::OFS_IN_OFF]  <= in_off_r;
      snap_r[lic_pkg::OFS_OUT_OFF] <= out_off_r;
      snap_r[lic_pkg::OFS_RESTART] <= restart_r;
      snap_r[lic_pkg::OFS_PWR]     <= pwr_r;
      snap_r[lic_pkg::OFS_SENSE]   <= sense_r;
      snap_r[lic_pkg::OFS_EQ_A]    <= group_a_eq_out;
      snap_r[lic_pkg::OFS_EQ_B]    <= group_b_eq_out;
      snap_r[lic_pkg::OFS_RSVD]    <= 8'h00;
      snap_r[lic_pkg::OFS_THRESH]  <= idle_threshold_out;
    end
  end

  // ************************************************************
  // Channel termination and lane routing
  // ************************************************************
  function automatic logic [3:0] chan_term(
    input logic lane_power_down, input logic rst, input logic sense, input logic load,
    input logic lvl, input logic in_off, input logic out_off);
    logic [1:0] it;
    logic [1:0] ot;
    it = lic_pkg::TERM_HIZ;
    ot = lic_pkg::TERM_HIZ;
    if (lane_power_down)
    begin
      if (!rst || (sense && !load))
        ot = lic_pkg::OUT_WEAK_UP;
      else
      begin
        it = lic_pkg::IN_PULL_DOWN;
        ot = lvl ? lic_pkg::OUT_DRIVE : lic_pkg::OUT_WEAK_UP;
      end
    end
    if (in_off)
      it = lic_pkg::TERM_HIZ;
    if (out_off)
      ot = lic_pkg::TERM_HIZ;
    return {it, ot};
  endfunction

  logic [3:0] term_c [lic_pkg::NUM_CH];
  logic [7:0] partner_c;
  logic [7:0] live_c;

  for (genvar i = 0; i < lic_pkg::NUM_CH; i++)
  begin : g_ch
    assign live_c[i] = pd_n_s & pwr_r[i];
    assign term_c[i] = chan_term(live_c[i], restart_r[i], sense_r[i],
                                 load_s[i], level_s[i], in_off_r[i],
                                 out_off_r[i]);
  end

  for (genvar k = 0; k < lic_pkg::NUM_LANES; k++)
  begin : g_lane
    assign partner_c[7-2*k] = 1'b0;
    assign partner_c[6-2*k] = ~loop_emph_r[7-k];
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      in_term_out         <= 16'h0000;
      out_term_out        <= 16'h0000;
      rx_enable_out       <= 8'h00;
      tx_enable_out       <= 8'h00;
      tx_from_partner_out <= 8'h00;
      detect_reset_out    <= 8'h00;
      detect_start_out    <= 8'h00;
      restart_q_r         <= 8'h00;
      lane_loop_n_out     <= 4'h0;
      emphasis_out        <= 2'h0;
    end
    else
    begin
      for (int i = 0; i < lic_pkg::NUM_CH; i++)
      begin
        in_term_out[2*i+:2]  <= term_c[i][3:2];
        out_term_out[2*i+:2] <= term_c[i][1:0];
        rx_enable_out[i]     <= (term_c[i][3:2] == lic_pkg::IN_PULL_DOWN);
        tx_enable_out[i]     <= (term_c[i][1:0] == lic_pkg::OUT_DRIVE);
      end
      detect_reset_out    <= live_c & ~restart_r;
      detect_start_out    <= live_c & sense_r & restart_r
                             & ~restart_q_r;
      restart_q_r         <= restart_r;
      tx_from_partner_out <= partner_c;
      lane_loop_n_out     <= loop_emph_r[7:4];
      emphasis_out        <= loop_emph_r[3:2];
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  power_off_hiz_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !pd_n_s |=> (in_term_out == 16'h0000 && out_term_out == 16'h0000))
    else $error("powered-down channel not high impedance");
  restart_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (live_c[0] && !restart_r[0] && !out_off_r[0])
    |=> (detect_reset_out[0] && out_term_out[1:0] == lic_pkg::OUT_WEAK_UP))
    else $error("restart low did not hold the channel");
  no_load_off_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (live_c[1] && restart_r[1] && sense_r[1] && !load_s[1])
    |=> in_term_out[3:2] == lic_pkg::TERM_HIZ)
    else $error("channel without load not off");
  load_drive_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (live_c[2] && restart_r[2] && load_s[2] && level_s[2] && !out_off_r[2])
    |=> tx_enable_out[2])
    else $error("loaded channel with level not driving");
  route_loop_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !loop_emph_r[7] |=> (tx_from_partner_out[6] && !tx_from_partner_out[7]))
    else $error("loop lane not routed A to B");
  in_disable_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    in_off_r[3] |=> !rx_enable_out[3])
    else $error("disabled input still enabled");
  write_lock_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (cfg_src_s && init_done_r) |=> $stable(in_off_r) && $stable(pwr_r))
    else $error("register changed while writes blocked");
  restart_pulse_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (live_c[4] && sense_r[4] && restart_r[4] && !restart_q_r[4])
    |=> detect_start_out[4] ##1 !detect_start_out[4])
    else $error("restart edge gave no single detect pulse");
  ack_drive_a: assert property (@(posedge scl_in) disable iff (!rstn_in)
    (st_r == lic_pkg::ST_WACK || st_r == lic_pkg::ST_ADDR_ACK) |-> sda_oe_out)
    else $error("acknowledge not driven");
  read_origin_a: assert property (@(posedge scl_in) disable iff (!rstn_in)
    (!new_start && st_r == lic_pkg::ST_ADDR_ACK && rw_r) |=> ptr_r == 4'h0)
    else $error("read did not start at byte zero");

  write_seen_c: cover property (@(posedge clk_in) disable iff (!rstn_in)
    wr_ok);
  drive_seen_c: cover property (@(posedge clk_in) disable iff (!rstn_in)
    tx_enable_out[0]);
  loop_seen_c: cover property (@(posedge clk_in) disable iff (!rstn_in)
    tx_from_partner_out[6]);
  read_seen_c: cover property (@(posedge scl_in) disable iff (!rstn_in)
    st_r == lic_pkg::ST_RACK && !sda_in);

endmodule // lic_top

`default_nettype wire

// File: tb/lic_i2c_host.sv
// I2C bus master model that configures the block under test.
`timescale 1ns/1ps
`default_nettype none

module lic_i2c_host (
  output logic      scl_out,
  output logic      pull_out,
  input  wire logic sda_in
);
  // ****************************************
  // Bus cycles; SCL stands high between frames.
  // ****************************************
  initial
  begin
    scl_out = 1'b1;
    pull_out = 1'b0;
  end
  // The long low after a start lets the slave freeze its map first.
  task automatic start();
    pull_out = 1'b1;
    #3 scl_out = 1'b0;
    #48;
  endtask
  task automatic stop();
    #1 pull_out = 1'b1;
    #3 scl_out = 1'b1;
    #3 pull_out = 1'b0;
    #6;
  endtask
  // Data moves only while SCL is low, so no false start or stop.
  task automatic bit_io(input logic b, output logic r);
    #1 pull_out = ~b;
    #2 scl_out = 1'b1;
    #3 r = sda_in;
    scl_out = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ack_tx,
    output logic [7:0] rx, output logic ack_rx);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ack_tx, ack_rx);
  endtask
endmodule // lic_i2c_host
`default_nettype wire

// File: tb/tb_lic_top.sv
// Self-checking bench for the lane control and configuration block.
`timescale 1ns/1ps
`default_nettype none

module tb_lic_top;
  logic        clk_in, rstn_in, cfg_src, pd_n, sda_oe, sda_drv, strap;
  logic [2:0]  asel;
  logic [7:0]  lvl, load, txp, eq_a, eq_b, thr, rxe, txe, dres, dstart;
  logic [1:0]  emph;
  logic [15:0] in_term, out_term;
  logic [3:0]  loop_n;
  logic [7:0]  wbuf [12];
  logic [7:0]  rbuf [12];
  int          fail_count, num_checks, starts;
  wire logic   scl, pull, sda;
  // ****************************************
  // Wiring; the data line has a pull-up.
  // ****************************************
  assign sda = pull ? 1'b0 : sda_oe ? sda_drv : 1'b1;
  lic_i2c_host H (.scl_out(scl), .pull_out(pull), .sda_in(sda));
  lic_top DUT (
    .clk_in(clk_in), .rstn_in(rstn_in), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_drv), .sda_oe_out(sda_oe), .addr_select_high_in(asel[2]),
    .addr_select_mid_in(asel[1]), .addr_select_low_in(asel[0]),
    .config_source_in(cfg_src), .power_down_n_in(pd_n),
    .loop_strap_n_in(strap), .detect_restart_n_in(1'b1),
    .load_sense_a_in(1'b0), .load_sense_b_in(1'b1),
    .level_valid_in(lvl), .load_found_in(load), .in_term_out(in_term),
    .out_term_out(out_term), .rx_enable_out(rxe), .tx_enable_out(txe),
    .tx_from_partner_out(txp), .detect_reset_out(dres),
    .detect_start_out(dstart), .lane_loop_n_out(loop_n),
    .emphasis_out(emph), .group_a_eq_out(eq_a),
    .group_b_eq_out(eq_b), .idle_threshold_out(thr));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    if (fail_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input int n);
    logic [7:0] r;
    logic       a;
    H.start();
    H.xfer(8'he2, 1'b1, r, a);
    check("address ack", a, 0);
    H.xfer(8'h5a, 1'b1, r, a);
    for (int i = 0; i < n; i++)
      H.xfer(wbuf[i], 1'b1, r, a);
    H.stop();
    repeat (8) @(posedge clk_in);
  endtask
  task automatic rd(input int n);
    logic a;
    H.start();
    H.xfer(8'he3, 1'b1, rbuf[0], a);
    for (int i = 0; i < n; i++)
      H.xfer(8'hff, i == n - 1, rbuf[i], a);
    H.stop();
    repeat (8) @(posedge clk_in);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_startup();
    logic [7:0] e [12] = '{8'h3c, 8'hc3, 8'hfc, 8'h00, 8'h00, 8'hff,
      8'hff, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00};
    rd(12);
    for (int i = 0; i < 12; i++)
      check("startup byte", rbuf[i], e[i]);
    check("loop bits", {loop_n, txp}, 12'hf00);
    check("emphasis", emph, 2'h3);
  endtask
  task automatic t_write();
    wbuf = '{8'h11, 8'h22, 8'ha3, 8'h00, 8'h00, 8'hff, 8'hff, 8'h55,
      8'h81, 8'h92, 8'h7e, 8'h4d};
    wr(12);
    rd(12);
    check("status", {rbuf[0], rbuf[1]}, 16'h3cc3);
    check("emphasis", emph, 2'h0);
    check("loop byte", rbuf[2], 8'ha0);
    check("spare", {rbuf[10], rbuf[11]}, 16'h004d);
    check("eq", {eq_a, eq_b, thr}, 24'h81924d);
    check("routing", {loop_n, txp}, 12'ha11);
  endtask
  task automatic t_block();
    cfg_src <= 1'b1;
    wbuf[8] = 8'h00;
    wr(9);
    check("blocked eq", eq_a, 8'h81);
    cfg_src <= 1'b0;
    wr(9);
    check("open eq", eq_a, 8'h00);
  endtask
  // Every mix of restart, sense, load, level and buffer disable.
  task automatic t_term();
    logic [1:0] ei, eo;
    logic       r, s, ld, lv, off;
    starts = 0;
    for (int i = 0; i < 32; i++)
    begin
      {off, r, s, ld, lv} = i[4:0];
      wbuf[3] = {8{off}};
      wbuf[4] = {8{off}};
      wbuf[5] = {8{r}};
      wbuf[7] = {8{s}};
      lvl <= {8{lv}};
      load <= {8{ld}};
      wr(8);
      ei = (!r || (s && !ld) || off) ? 2'h0 : 2'h1;
      eo = off ? 2'h0 : (!r || (s && !ld) || !lv) ? 2'h1 : 2'h2;
      check("in term", in_term[1:0], ei);
      check("out term", out_term[1:0], eo);
      check("rx enable", rxe[0], ei == 2'h1);
      check("tx enable", txe[0], eo == 2'h2);
      check("detect reset", dres[0], !r);
    end
    check("detect starts", starts, 2);
  endtask
  // A second reset with the loop strap low must load loop mode.
  task automatic t_strap();
    strap <= 1'b0;
    rstn_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    check("strap loop", {loop_n, txp}, 12'h055);
  endtask
  task automatic t_power();
    wbuf[3] = 8'h00;
    wbuf[4] = 8'h00;
    wbuf[6] = 8'h7f;
    wbuf[7] = 8'h00;
    wr(8);
    check("one off", {in_term, out_term}, 32'h15552aaa);
    pd_n <= 1'b0;
    repeat (6) @(posedge clk_in);
    check("all off", {in_term, out_term}, 32'h0);
  endtask
  task automatic t_addr();
    logic [7:0] r;
    logic       a;
    asel <= 3'b001;
    @(posedge clk_in);
    H.start();
    H.xfer(8'he2, 1'b1, r, a);
    H.stop();
    check("foreign address", a, 1);
  endtask
  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
    if (dstart[0] === 1'b1)
      starts++;
  initial
  begin
    #300000;
    fail_count++;
    summarize();
  end
  initial
  begin
    {rstn_in, cfg_src, pd_n, strap, asel} = 7'b0011101;
    lvl = 8'h3c;
    load = 8'hc3;
    fail_count = 0;
    num_checks = 0;
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    t_startup();
    t_write();
    t_block();
    t_term();
    t_power();
    t_addr();
    t_strap();
    summarize();
  end
endmodule // tb_lic_top
`default_nettype wire
